/* File: rtl/hfcw_ctrl_word_access.sv */
module hfcw_ctrl_word_access #(
  parameter bit MAC_INCLUDED = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire hfcw_pkg::hfcw_avs_req_t avs_req,
  output logic [hfcw_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_readdatavalid,
  input wire hfcw_pkg::hfcw_cw_t rx_cw,
  input wire hfcw_pkg::hfcw_cw_t tx_cw_req,
  output hfcw_pkg::hfcw_byte_t tx_cw_out,
  input wire hfcw_pkg::hfcw_eth_rx_t rx_eth,
  input wire logic tx_eth_take,
  output hfcw_pkg::hfcw_byte_t tx_eth,
  output logic [hfcw_pkg::BYTE_W-1:0] rx_eth_pointer,
  output logic eth_channel_present,
  output logic eth_mac_reset
);

  localparam hfcw_pkg::hfcw_state_t STATE_RESET = '0;

  hfcw_pkg::hfcw_state_t s_reg;
  hfcw_pkg::hfcw_state_t s_next;

  function automatic logic [hfcw_pkg::BYTE_W-1:0] cw_index(
    input logic [5:0] ns,
    input logic [1:0] xs
  );
    return 8'({2'h0, ns}) + 8'({6'h00, xs}) * hfcw_pkg::SUBCH_COUNT;
  endfunction

  function automatic logic is_eth_reg(
    input logic [hfcw_pkg::ADDR_W-1:0] addr
  );
    return (addr == hfcw_pkg::OFF_ETH_CFG) || (addr == hfcw_pkg::OFF_ETH_RX_BYTE)
      || (addr == hfcw_pkg::OFF_ETH_TX_BYTE);
  endfunction

  function automatic logic ptr_valid(
    input logic [hfcw_pkg::BYTE_W-1:0] v
  );
    return (v == hfcw_pkg::PTR_NONE) || ((v >= hfcw_pkg::PTR_MIN) && (v <= hfcw_pkg::PTR_MAX));
  endfunction

  always_comb
  begin
    logic [hfcw_pkg::BYTE_W-1:0] rx_idx;
    logic [hfcw_pkg::BYTE_W-1:0] tx_idx;
    logic [hfcw_pkg::BYTE_W:0] tx_entry;
    logic eth_ok;
    logic [hfcw_pkg::LEN_W-1:0] len_inc;
    rx_idx = cw_index(rx_cw.ns, rx_cw.xs);
    tx_idx = cw_index(tx_cw_req.ns, tx_cw_req.xs);
    tx_entry = s_reg.tx_table[tx_idx];
    eth_ok = MAC_INCLUDED;
    len_inc = '0;
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.eth_reset = 1'b0;
    s_next.tx_out_valid = 1'b0;

    // Host reads, one cycle latency; decode on the single slave port
    if (avs_req.read)
    begin
      s_next.rvalid = 1'b1;
      if (is_eth_reg(avs_req.address) && !eth_ok)
      begin
        s_next.rdata = '0;
      end
      else
      begin
        case (avs_req.address)
          hfcw_pkg::OFF_CONFIG:
          begin
            s_next.rdata = 32'(s_reg.insert_en);
          end
          hfcw_pkg::OFF_INDEX:
          begin
            s_next.rdata = 32'(s_reg.index);
          end
          hfcw_pkg::OFF_RX_CTRL:
          begin
            s_next.rdata = 32'(s_reg.rx_table[s_reg.index]);
          end
          hfcw_pkg::OFF_TX_CTRL:
          begin
            s_next.rdata = 32'(s_reg.tx_table[s_reg.index]);
          end
          hfcw_pkg::OFF_MGMT_CFG:
          begin
            s_next.rdata = 32'(s_reg.ptr_cfg);
          end
          hfcw_pkg::OFF_MGMT_STAT:
          begin
            s_next.rdata = 32'(s_reg.ptr_status);
          end
          hfcw_pkg::OFF_ETH_CFG:
          begin
            s_next.rdata = 32'(s_reg.eth_cfg);
          end
          hfcw_pkg::OFF_ETH_RX_BYTE:
          begin
            s_next.rdata = 32'({s_reg.eth_rx_ready, s_reg.eth_rx_byte});
            s_next.eth_rx_ready = 1'b0;
          end
          hfcw_pkg::OFF_ETH_TX_BYTE:
          begin
            s_next.rdata = 32'({s_reg.eth_tx_pending, s_reg.eth_tx_byte});
          end
          default:
          begin
            s_next.rdata = '0;
          end
        endcase
      end
    end

    // Ethernet byte consumed by the framer
    if (tx_eth_take)
    begin
      s_next.eth_tx_pending = 1'b0;
    end

    // Host writes; ethernet registers dropped when MAC absent
    if (avs_req.write && !(is_eth_reg(avs_req.address) && !eth_ok))
    begin
      case (avs_req.address)
        hfcw_pkg::OFF_CONFIG:
        begin
          s_next.insert_en = avs_req.writedata[hfcw_pkg::CFG_INSERT_EN_BIT];
        end
        hfcw_pkg::OFF_INDEX:
        begin
          s_next.index = avs_req.writedata[hfcw_pkg::BYTE_W-1:0];
        end
        hfcw_pkg::OFF_TX_CTRL:
        begin
          s_next.tx_table[s_reg.index] = avs_req.writedata[hfcw_pkg::TXC_INSERT_BIT:0];
        end
        hfcw_pkg::OFF_MGMT_CFG:
        begin
          // Software set-up also seeds the received pointer
          s_next.ptr_cfg = avs_req.writedata[hfcw_pkg::BYTE_W-1:0];
          s_next.ptr_status = avs_req.writedata[hfcw_pkg::BYTE_W-1:0];
          s_next.cand_state = hfcw_pkg::HFCW_CAND_NONE;
        end
        hfcw_pkg::OFF_ETH_CFG:
        begin
          s_next.eth_cfg = avs_req.writedata[hfcw_pkg::BYTE_W-1:0];
        end
        hfcw_pkg::OFF_ETH_TX_BYTE:
        begin
          s_next.eth_tx_byte = avs_req.writedata[hfcw_pkg::BYTE_W-1:0];
          s_next.eth_tx_pending = 1'b1;
        end
        default:
        begin
        end
      endcase
    end

    // Receive side: latest first byte per control word
    if (rx_cw.valid)
    begin
      s_next.rx_table[rx_idx] = rx_cw.data;
      if (rx_idx == hfcw_pkg::PTR_CW_INDEX)
      begin
        if (!ptr_valid(rx_cw.data) || (rx_cw.data == s_reg.ptr_status))
        begin
          s_next.cand_state = hfcw_pkg::HFCW_CAND_NONE;
        end
        else if ((s_reg.cand_state == hfcw_pkg::HFCW_CAND_NONE) || (rx_cw.data != s_reg.ptr_cand))
        begin
          s_next.ptr_cand = rx_cw.data;
          s_next.cand_state = hfcw_pkg::HFCW_CAND_ONE;
        end
        else
        begin
          case (s_reg.cand_state)
            hfcw_pkg::HFCW_CAND_ONE:
            begin
              s_next.cand_state = hfcw_pkg::HFCW_CAND_TWO;
            end
            hfcw_pkg::HFCW_CAND_TWO:
            begin
              s_next.cand_state = hfcw_pkg::HFCW_CAND_THREE;
            end
            hfcw_pkg::HFCW_CAND_THREE:
            begin
              // Fourth hyperframe in a row with the same value
              s_next.ptr_status = s_reg.ptr_cand;
              s_next.cand_state = hfcw_pkg::HFCW_CAND_NONE;
            end
            default:
            begin
              s_next.cand_state = hfcw_pkg::HFCW_CAND_NONE;
            end
          endcase
        end
      end
    end
    s_next.chan_present = (s_next.ptr_status != hfcw_pkg::PTR_NONE);

    // Transmit side: pointer byte, then table insertion
    if (tx_cw_req.valid)
    begin
      s_next.tx_out_valid = 1'b1;
      if (tx_idx == hfcw_pkg::PTR_CW_INDEX)
      begin
        s_next.tx_out_data = s_reg.ptr_cfg;
      end
      else if (s_reg.insert_en && tx_entry[hfcw_pkg::TXC_INSERT_BIT])
      begin
        s_next.tx_out_data = tx_entry[hfcw_pkg::BYTE_W-1:0];
      end
      else
      begin
        s_next.tx_out_data = tx_cw_req.data;
      end
    end

    // Ethernet receive extraction and length guard
    if (eth_ok && rx_eth.valid)
    begin
      if (s_reg.eth_len == hfcw_pkg::ETH_LEN_SAT)
      begin
        len_inc = s_reg.eth_len;
      end
      else
      begin
        len_inc = s_reg.eth_len + hfcw_pkg::ETH_LEN_ONE;
      end
      s_next.eth_len = rx_eth.sof ? hfcw_pkg::ETH_LEN_ONE : len_inc;
      s_next.eth_rx_byte = rx_eth.data;
      s_next.eth_rx_ready = 1'b1;
      if ((s_next.eth_len > hfcw_pkg::ETH_MAX_LEN) && !s_reg.eth_cfg[hfcw_pkg::ETH_LONG_ALLOW_BIT])
      begin
        s_next.eth_reset = 1'b1;
        s_next.eth_len = '0;
        s_next.eth_rx_ready = 1'b0;
        s_next.eth_tx_pending = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= STATE_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = s_reg.rdata;
  assign avs_readdatavalid = s_reg.rvalid;
  assign tx_cw_out.valid = s_reg.tx_out_valid;
  assign tx_cw_out.data = s_reg.tx_out_data;
  assign tx_eth.valid = s_reg.eth_tx_pending;
  assign tx_eth.data = s_reg.eth_tx_byte;
  assign rx_eth_pointer = s_reg.ptr_status;
  assign eth_channel_present = s_reg.chan_present;
  assign eth_mac_reset = s_reg.eth_reset;

endmodule

/* File: rtl/hfcw_pkg.sv */
package hfcw_pkg;

  // Table geometry
  localparam int CW_COUNT = 256;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int LEN_W = 11;
  localparam logic [7:0] SUBCH_COUNT = 8'h40;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 10'h000;
  localparam logic [ADDR_W-1:0] OFF_INDEX = 10'h004;
  localparam logic [ADDR_W-1:0] OFF_RX_CTRL = 10'h008;
  localparam logic [ADDR_W-1:0] OFF_TX_CTRL = 10'h00C;
  localparam logic [ADDR_W-1:0] OFF_MGMT_CFG = 10'h010;
  localparam logic [ADDR_W-1:0] OFF_MGMT_STAT = 10'h014;
  localparam logic [ADDR_W-1:0] OFF_ETH_RX_BYTE = 10'h0E0;
  localparam logic [ADDR_W-1:0] OFF_ETH_TX_BYTE = 10'h0E4;
  localparam logic [ADDR_W-1:0] OFF_ETH_CFG = 10'h208;

  // Field positions
  localparam int CFG_INSERT_EN_BIT = 0;
  localparam int TXC_INSERT_BIT = 8;
  localparam int ETH_LONG_ALLOW_BIT = 4;
  localparam int ETH_FLAG_BIT = 8;

  // Pointer in control byte 194
  localparam logic [7:0] PTR_CW_INDEX = 8'hC2;
  localparam logic [7:0] PTR_NONE = 8'h00;
  localparam logic [7:0] PTR_MIN = 8'h14;
  localparam logic [7:0] PTR_MAX = 8'h3F;

  // Longest ethernet frame before self reset
  localparam logic [LEN_W-1:0] ETH_MAX_LEN = 11'h600;
  localparam logic [LEN_W-1:0] ETH_LEN_SAT = 11'h7FF;
  localparam logic [LEN_W-1:0] ETH_LEN_ONE = 11'h001;

  typedef enum logic [1:0] {
    HFCW_CAND_NONE = 2'h0,
    HFCW_CAND_ONE = 2'h1,
    HFCW_CAND_TWO = 2'h3,
    HFCW_CAND_THREE = 2'h2
  } hfcw_cand_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } hfcw_avs_req_t;

  typedef struct packed {
    logic valid;
    logic [5:0] ns;
    logic [1:0] xs;
    logic [BYTE_W-1:0] data;
  } hfcw_cw_t;

  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } hfcw_byte_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic [BYTE_W-1:0] data;
  } hfcw_eth_rx_t;

  typedef struct packed {
    logic [BYTE_W-1:0] index;
    logic insert_en;
    logic [CW_COUNT-1:0][BYTE_W:0] tx_table;
    logic [CW_COUNT-1:0][BYTE_W-1:0] rx_table;
    logic [BYTE_W-1:0] ptr_cfg;
    logic [BYTE_W-1:0] ptr_status;
    logic [BYTE_W-1:0] ptr_cand;
    hfcw_cand_t cand_state;
    logic chan_present;
    logic [BYTE_W-1:0] eth_cfg;
    logic [LEN_W-1:0] eth_len;
    logic [BYTE_W-1:0] eth_rx_byte;
    logic eth_rx_ready;
    logic [BYTE_W-1:0] eth_tx_byte;
    logic eth_tx_pending;
    logic eth_reset;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [BYTE_W-1:0] tx_out_data;
    logic tx_out_valid;
  } hfcw_state_t;

endpackage

/* File: tb/hfcw_ctrl_word_access_assertions.sv */
module hfcw_ctrl_word_access_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire hfcw_pkg::hfcw_avs_req_t avs_req,
  input wire logic [hfcw_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_readdatavalid,
  input wire hfcw_pkg::hfcw_cw_t rx_cw,
  input wire hfcw_pkg::hfcw_cw_t tx_cw_req,
  input wire hfcw_pkg::hfcw_byte_t tx_cw_out,
  input wire hfcw_pkg::hfcw_eth_rx_t rx_eth,
  input wire logic tx_eth_take,
  input wire hfcw_pkg::hfcw_byte_t tx_eth,
  input wire logic [hfcw_pkg::BYTE_W-1:0] rx_eth_pointer,
  input wire logic eth_channel_present,
  input wire logic eth_mac_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ptr_evt;
  // Pointer byte arrival or pointer config write
  assign ptr_evt = (rx_cw.valid && rx_cw.ns == 6'h02 && rx_cw.xs == 2'h3)
    || (avs_req.write && avs_req.address == hfcw_pkg::OFF_MGMT_CFG);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_rd_latency: assert property (avs_req.read |=> avs_readdatavalid)
    else $error("read not answered");
  a_rd_spurious: assert property (avs_readdatavalid |-> $past(avs_req.read))
    else $error("stray read valid");
  a_rx_upper_zero: assert property (avs_req.read && avs_req.address == hfcw_pkg::OFF_RX_CTRL
    |=> avs_readdata[31:8] == 24'h000000) else $error("rx upper bits set");
  a_tx_latency: assert property (tx_cw_req.valid |=> tx_cw_out.valid)
    else $error("tx word not answered");
  a_tx_spurious: assert property (tx_cw_out.valid |-> $past(tx_cw_req.valid))
    else $error("stray tx word");
  a_chan_present: assert property (eth_channel_present == (rx_eth_pointer != 8'h00))
    else $error("channel flag wrong");
  a_ptr_cause: assert property ($changed(rx_eth_pointer) |-> $past(ptr_evt))
    else $error("pointer changed without cause");
  a_mac_rst_pulse: assert property (eth_mac_reset |=> !eth_mac_reset)
    else $error("reset pulse too long");
  a_eth_pending: assert property (tx_eth.valid && !tx_eth_take
    |=> tx_eth.valid || eth_mac_reset || $past(eth_mac_reset)) else $error("pending lost");
  c_mac_rst: cover property (eth_mac_reset);
  c_ptr_change: cover property ($changed(rx_eth_pointer));
  c_tx_insert: cover property (tx_cw_out.valid && tx_cw_out.data != 8'h00);
endmodule

bind hfcw_ctrl_word_access hfcw_ctrl_word_access_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_readdatavalid(avs_readdatavalid), .rx_cw(rx_cw),
  .tx_cw_req(tx_cw_req), .tx_cw_out(tx_cw_out), .rx_eth(rx_eth), .tx_eth_take(tx_eth_take),
  .tx_eth(tx_eth), .rx_eth_pointer(rx_eth_pointer), .eth_channel_present(eth_channel_present),
  .eth_mac_reset(eth_mac_reset));

/* File: tb/hfcw_host_model.sv */
module hfcw_host_model (
  input wire logic clk_sys,
  output hfcw_pkg::hfcw_avs_req_t avs_req,
  input wire logic [hfcw_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_readdatavalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial avs_req = '0;
  // One access at a time on the single port, idle cycle between
  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_req <= '{1'b0, 1'b1, a, d};
    @(posedge clk_sys);
    avs_req <= '0;
  endtask
  // Read issued no earlier than the cycle after an index write
  task rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_req <= '{1'b1, 1'b0, a, 32'h00000000};
    @(posedge clk_sys);
    avs_req <= '0;
    @(posedge clk_sys);
    d = avs_readdatavalid ? avs_readdata : 32'hFFFFFFFF;
  endtask
endmodule

/* File: tb/hfcw_ctrl_word_access_tb_top.sv */
module hfcw_ctrl_word_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  hfcw_pkg::hfcw_avs_req_t avs_req;
  logic [31:0] avs_readdata;
  logic avs_readdatavalid;
  hfcw_pkg::hfcw_cw_t rx_cw = '0;
  hfcw_pkg::hfcw_cw_t tx_cw_req = '0;
  hfcw_pkg::hfcw_byte_t tx_cw_out;
  hfcw_pkg::hfcw_eth_rx_t rx_eth = '0;
  logic tx_eth_take = 1'b0;
  hfcw_pkg::hfcw_byte_t tx_eth;
  logic [7:0] rx_eth_pointer;
  logic eth_channel_present;
  logic eth_mac_reset;
  int err_total = 0;
  int n_tests = 0;
  int n_rst = 0;
  int cnt = 0;
  logic [31:0] seed = 32'h00006034;
  logic [7:0] rxm [256] = '{default: 8'h00};
  logic [8:0] txm [256] = '{default: 9'h000};
  logic [7:0] pv [16] = '{8'h20, 8'h20, 8'h20, 8'h21, 8'h20, 8'h20, 8'h20, 8'h20,
    8'h05, 8'h05, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] pst = 8'h00;
  logic [7:0] pc = 8'h00;
  logic [7:0] pcfg = 8'h00;
  logic [7:0] x;
  logic ins = 1'b0;
  logic [31:0] d;

  hfcw_ctrl_word_access u_hfcw_ctrl_word_access (.clk_sys(clk_sys), .rst_n(rst_n), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_readdatavalid(avs_readdatavalid), .rx_cw(rx_cw),
    .tx_cw_req(tx_cw_req), .tx_cw_out(tx_cw_out), .rx_eth(rx_eth), .tx_eth_take(tx_eth_take),
    .tx_eth(tx_eth), .rx_eth_pointer(rx_eth_pointer), .eth_channel_present(eth_channel_present),
    .eth_mac_reset(eth_mac_reset));
  hfcw_host_model u_hfcw_host_model (.clk_sys(clk_sys), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_readdatavalid(avs_readdatavalid));

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (eth_mac_reset === 1'b1) n_rst <= n_rst + 1;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [31:0] v);
    u_hfcw_host_model.wr(a, v);
  endtask
  task rdc(input logic [9:0] a, input logic [31:0] e);
    u_hfcw_host_model.rd(a, d);
    chk(d, e, "read");
  endtask
  // Received first byte, with the pointer filter at word 194
  task rxw(input logic [7:0] i, input logic [7:0] b);
    @(posedge clk_sys);
    rx_cw <= '{1'b1, i[5:0], i[7:6], b};
    @(posedge clk_sys);
    rx_cw <= '0;
    rxm[i] = b;
    if (i == 8'hC2)
    begin
      if ((b == 8'h00 || (b >= 8'h14 && b <= 8'h3F)) && b != pst)
      begin
        cnt = b == pc ? cnt + 1 : 1;
        pc = b;
        if (cnt == 4) pst = b;
      end
      else cnt = 0;
    end
  endtask
  task txw(input logic [7:0] i, input logic [7:0] b);
    logic [7:0] e;
    e = i == 8'hC2 ? pcfg : (ins && txm[i][8]) ? txm[i][7:0] : b;
    @(posedge clk_sys);
    tx_cw_req <= '{1'b1, i[5:0], i[7:6], b};
    @(posedge clk_sys);
    tx_cw_req <= '0;
    @(posedge clk_sys);
    chk(32'(tx_cw_out), {23'h0, 1'b1, e}, "tx word");
  endtask
  task frame();
    for (int i = 0; i < 1537; i++)
    begin
      @(posedge clk_sys);
      rx_eth <= '{1'b1, i == 0, rnd()};
    end
    @(posedge clk_sys);
    rx_eth <= '0;
    repeat (4) @(posedge clk_sys);
  endtask
  task report_and_stop();
    $display("counts: %0d tests, %0d errors", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(hfcw_pkg::OFF_CONFIG, 0);
    rdc(hfcw_pkg::OFF_INDEX, 0);
    rdc(hfcw_pkg::OFF_MGMT_STAT, 0);
    rdc(10'h3FC, 0);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      x = k < 4 ? 8'(16 + 64 * k) : rnd();
      rxw(x, rnd());
      rxw(x, rnd());
      wr(hfcw_pkg::OFF_INDEX, 32'(x));
      rdc(hfcw_pkg::OFF_INDEX, 32'(x));
      rdc(hfcw_pkg::OFF_RX_CTRL, 32'(rxm[x]));
    end
    $display("test rx table done");
    for (int k = 0; k < 4; k++)
    begin
      x = 8'(16 + 64 * k);
      txm[x] = {k != 1, rnd()};
      wr(hfcw_pkg::OFF_INDEX, 32'(x));
      wr(hfcw_pkg::OFF_TX_CTRL, 32'(txm[x]));
      rdc(hfcw_pkg::OFF_TX_CTRL, 32'(txm[x]));
    end
    for (int on = 0; on < 2; on++)
    begin
      ins = on[0];
      wr(hfcw_pkg::OFF_CONFIG, 32'(on));
      for (int k = 0; k < 4; k++) txw(8'(16 + 64 * k), 8'h5A);
    end
    wr(10'h3FC, 32'hFFFFFFFF);
    rdc(hfcw_pkg::OFF_CONFIG, 1);
    $display("test tx table done");
    pcfg = 8'h14;
    wr(hfcw_pkg::OFF_MGMT_CFG, 32'(pcfg));
    pst = pcfg;
    cnt = 0;
    rdc(hfcw_pkg::OFF_MGMT_STAT, 32'(pst));
    txw(8'hC2, 8'hAA);
    foreach (pv[i])
    begin
      rxw(8'hC2, pv[i]);
      repeat (2) @(posedge clk_sys);
      chk(32'(rx_eth_pointer), 32'(pst), "pointer");
      chk(32'(eth_channel_present), 32'(pst != 8'h00), "channel");
    end
    $display("test pointer done");
    wr(hfcw_pkg::OFF_ETH_CFG, 0);
    frame();
    chk(32'(n_rst), 1, "long frame");
    wr(hfcw_pkg::OFF_ETH_CFG, 32'h10);
    rdc(hfcw_pkg::OFF_ETH_CFG, 32'h10);
    frame();
    chk(32'(n_rst), 1, "allowed frame");
    wr(hfcw_pkg::OFF_ETH_TX_BYTE, 32'h5A);
    @(posedge clk_sys);
    chk(32'(tx_eth), 32'h15A, "eth tx");
    @(posedge clk_sys);
    tx_eth_take <= 1'b1;
    @(posedge clk_sys);
    tx_eth_take <= 1'b0;
    @(posedge clk_sys);
    chk(32'(tx_eth.valid), 0, "eth take");
    $display("test ethernet done");
    report_and_stop();
  end
endmodule
